// *** dv/pmc_top_sva.sv ***
// Assertion checker on the power mode controller ports
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.vh"

module pmc_top_sva #(
  parameter int N_SUBSYS  = 8,
  parameter int SLEEP_RES = 20,
  parameter int HIB_RES   = 40
) (
  input wire logic                I_REF_CLK,
  input wire logic                I_RESET_N,
  input wire logic [N_SUBSYS-1:0] O_SUBSYS_EN,
  input wire logic [N_SUBSYS-1:0] O_SUBSYS_CLK,
  input wire logic [1:0]          O_MODE,
  input wire logic                O_LS_OSC_EN,
  input wire logic                O_TIMER_KEEP,
  input wire logic                O_MAIN_REG_EN,
  input wire logic                O_REG_BUZZ,
  input wire logic                O_IO_HOLD
);
  // Resume cycles: old low-power code shown with regulators back on
  logic [15:0] res_run_q;
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      res_run_q <= 16'h0000;
    end else if (O_MODE[1] && O_MAIN_REG_EN) begin
      res_run_q <= res_run_q + 16'h0001;
    end else begin
      res_run_q <= 16'h0000;
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence s_deep(m);
    O_MODE == m && !O_MAIN_REG_EN;
  endsequence
  sequence s_resume(m);
    s_deep(m) ##1 (O_MAIN_REG_EN && O_MODE == m);
  endsequence
  property p_sleep_quiet;
    s_deep(`PMC_MODE_SLEEP) |-> O_SUBSYS_EN == '0 && O_LS_OSC_EN && O_TIMER_KEEP;
  endproperty
  property p_hib_quiet;
    s_deep(`PMC_MODE_HIB) |-> O_SUBSYS_EN == '0 && !O_LS_OSC_EN && !O_TIMER_KEEP && O_IO_HOLD;
  endproperty
  property p_no_exit;
    O_MODE[1] && !O_MAIN_REG_EN |=> O_MODE == $past(O_MODE);
  endproperty
  // Long resume counts exceed a delay range, so a counter bounds them
  property p_sleep_res;
    O_MODE == `PMC_MODE_SLEEP && O_MAIN_REG_EN |-> res_run_q < SLEEP_RES;
  endproperty
  property p_hib_res;
    O_MODE == `PMC_MODE_HIB && O_MAIN_REG_EN |-> res_run_q < HIB_RES;
  endproperty
  property p_res_dark;
    s_resume(`PMC_MODE_HIB) |-> O_SUBSYS_EN == '0 && O_LS_OSC_EN && !O_IO_HOLD;
  endproperty
  property p_wake_cpu;
    O_MODE == `PMC_MODE_ACTIVE && $past(O_MODE[1]) |-> ##[0:1] O_SUBSYS_EN[0];
  endproperty
  property p_buzz_mode;
    O_REG_BUZZ |-> O_MODE == `PMC_MODE_SLEEP;
  endproperty
  property p_buzz_gap;
    O_REG_BUZZ |=> !O_REG_BUZZ [*6];
  endproperty
  // High phase follows the enable latched on the last falling edge
  property p_clk_gate;
    @(negedge I_REF_CLK) disable iff (!I_RESET_N) O_SUBSYS_CLK == $past(O_SUBSYS_EN);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep outputs wrong");
  a_hib_quiet: assert property (p_hib_quiet) else $error("hibernate outputs wrong");
  a_no_exit: assert property (p_no_exit) else $error("low power left without wake");
  a_sleep_res: assert property (p_sleep_res) else $error("sleep resume too slow");
  a_hib_res: assert property (p_hib_res) else $error("hibernate resume too slow");
  a_res_dark: assert property (p_res_dark) else $error("resume outputs wrong");
  a_wake_cpu: assert property (p_wake_cpu) else $error("cpu off after wake");
  a_buzz_mode: assert property (p_buzz_mode) else $error("buzz outside sleep");
  a_buzz_gap: assert property (p_buzz_gap) else $error("buzz too often");
  a_clk_gate: assert property (p_clk_gate) else $error("gated clock glitch");
endmodule // pmc_top_sva

bind pmc_top pmc_top_sva #(
  .N_SUBSYS(N_SUBSYS), .SLEEP_RES(SLEEP_RES), .HIB_RES(HIB_RES)
) u_pmc_top_sva (
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .O_SUBSYS_EN(O_SUBSYS_EN),
  .O_SUBSYS_CLK(O_SUBSYS_CLK), .O_MODE(O_MODE), .O_LS_OSC_EN(O_LS_OSC_EN),
  .O_TIMER_KEEP(O_TIMER_KEEP), .O_MAIN_REG_EN(O_MAIN_REG_EN),
  .O_REG_BUZZ(O_REG_BUZZ), .O_IO_HOLD(O_IO_HOLD)
);

`default_nettype wire

// *** dv/pmc_top_tb.sv ***
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.vh"

module pmc_top_tb;
  localparam int SR = 20;
  localparam int HR = 40;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        pen = 1'h0;
  logic        pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  wreq = 6'h00;
  logic [31:0] rd;
  logic        er;
  wire  [5:0]  wake;
  wire  [31:0] rdata;
  wire  [7:0]  sen, sclk;
  wire  [1:0]  mode;
  wire         rdy, slverr, ls, tk, mreg, buzz, hold;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          nb;

  pmc_wake_model u_pmc_wake_model (.i_clk(clk), .i_req(wreq), .o_wake(wake));
  pmc_top #(.SLEEP_RES(SR), .HIB_RES(HR), .BUZZ_PERIOD(8)) u_pmc_top (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(rdy), .O_PRDATA(rdata),
    .O_PSLVERR(slverr), .I_WAKE_SRC(wake), .O_SUBSYS_EN(sen), .O_SUBSYS_CLK(sclk),
    .O_MODE(mode), .O_LS_OSC_EN(ls), .O_TIMER_KEEP(tk), .O_MAIN_REG_EN(mreg),
    .O_REG_BUZZ(buzz), .O_IO_HOLD(hold));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    rd = rdata;
    er = slverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Hold a wake level until active returns, within a bound
  task automatic wake_to_active(input logic [5:0] src, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    wreq <= src;
    while (mode !== `PMC_MODE_ACTIVE && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("resume_time", n < lim, 1);
    wreq <= 6'h00;
  endtask

  task automatic t_reset;
    chk("mode_rst", mode, `PMC_MODE_ACTIVE);
    chk("en_rst", sen, `PMC_ACT_TMPL_RST);
    apb(1'h0, `PMC_ALT_TMPL_OFS, 0);
    chk("alt_rst", rd, `PMC_ALT_TMPL_RST);
    apb(1'h0, `PMC_WAKE_EN_OFS, 0);
    chk("wake_rst", rd, `PMC_WAKE_EN_RST);
    apb(1'h0, 12'h01C, 0);
    chk("unmapped_err", er, 1);
    chk("unmapped_rd", rd, 0);
  endtask
  task automatic t_sleep;
    apb(1'h1, `PMC_ACT_TMPL_OFS, 32'h0E);
    tick(2);
    chk("cpu_off", sen, 8'h0E);
    @(posedge clk);
    wreq <= 6'h04;
    @(posedge clk);
    wreq <= 6'h00;
    tick(6);
    chk("cpu_wake", sen, 8'h0F);
    apb(1'h1, `PMC_ACT_TMPL_OFS, 32'h0E);
    apb(1'h1, `PMC_WAKE_EN_OFS, 32'h08);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_SLEEP);
    tick(2);
    chk("sl_mode", {mode, sen}, 10'h200);
    chk("sl_clk", {ls, tk, mreg}, 3'h6);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_ACTIVE);
    tick(2);
    chk("sl_stay", mode, `PMC_MODE_SLEEP);
    apb(1'h0, `PMC_STATUS_OFS, 0);
    chk("refused", rd[3], 1);
    nb = 0;
    repeat (16) begin
      @(posedge clk);
      #1;
      nb += buzz;
    end
    chk("buzz", nb, 2);
    @(posedge clk);
    wreq <= 6'h01;
    tick(10);
    chk("off_src", mode, `PMC_MODE_SLEEP);
    wake_to_active(6'h08, SR + 8);
    tick(2);
    chk("sl_wake", sen, 8'h0F);
    apb(1'h0, `PMC_STATUS_OFS, 0);
    chk("cause", rd[13:8], 6'h08);
  endtask
  task automatic t_hib;
    apb(1'h1, `PMC_WAKE_EN_OFS, 32'h3F);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_ALT);
    tick(2);
    chk("alt", {mode, sen}, 10'h1FE);
    apb(1'h0, `PMC_MODE_CTRL_OFS, 0);
    chk("mode_rd", rd, `PMC_MODE_ALT);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_HIB);
    tick(2);
    chk("alt_hib", mode, `PMC_MODE_ALT);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_ACTIVE);
    apb(1'h1, `PMC_MODE_CTRL_OFS, `PMC_MODE_HIB);
    tick(2);
    chk("hib", {mode, sen, ls, tk, mreg, hold}, 14'h3001);
    @(posedge clk);
    wreq <= 6'h3D;
    tick(10);
    chk("hib_stay", mode, `PMC_MODE_HIB);
    wake_to_active(6'h02, HR + 8);
    tick(2);
    chk("hib_wake", {sen[0], hold}, 2'h2);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    tick(1);
    t_reset;
    t_sleep;
    t_hib;
    print_verdict;
  end
endmodule // pmc_top_tb

`default_nettype wire

// *** dv/pmc_wake_model.sv ***
// Behavioural wake event sources facing the power mode controller
`timescale 1ns/1ns
`default_nettype none

module pmc_wake_model (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_req,
  output var  logic [5:0] o_wake
);
  initial o_wake = 6'h00;
  always @(posedge i_clk) begin
    o_wake <= i_req;
  end
endmodule // pmc_wake_model

`default_nettype wire

// *** src/pmc_map.vh ***
// Register map, field positions, reset values and timing for the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// Register byte offsets
`define PMC_MODE_CTRL_OFS   12'h000
`define PMC_ACT_TMPL_OFS    12'h004
`define PMC_ALT_TMPL_OFS    12'h008
`define PMC_WAKE_EN_OFS     12'h00C
`define PMC_STATUS_OFS      12'h010

// Mode codes, used in the request field and in status
`define PMC_MODE_W          2
`define PMC_MODE_ACTIVE     2'h0
`define PMC_MODE_ALT        2'h1
`define PMC_MODE_SLEEP      2'h2
`define PMC_MODE_HIB        2'h3

// Template bit that enables the CPU
`define PMC_CPU_BIT         0

// Wakeup source bit positions
`define PMC_WAKE_W          6
`define PMC_WK_COMP         0
`define PMC_WK_PIN_INT      1
`define PMC_WK_I2C          2
`define PMC_WK_RTC          3
`define PMC_WK_TIMEWHEEL    4
`define PMC_WK_LVD          5

// Status field positions
`define PMC_ST_MODE_LSB     0
`define PMC_ST_RESUMING     2
`define PMC_ST_REFUSED      3
`define PMC_ST_CAUSE_LSB    8

// Reset values
`define PMC_ACT_TMPL_RST    8'hFF
`define PMC_ALT_TMPL_RST    8'hFE
`define PMC_WAKE_EN_RST     6'h3F

// Timing: clock rate and resume limits
`define PMC_CLK_MHZ         100
`define PMC_SLEEP_RES_NS    15000
`define PMC_HIB_RES_NS      100000
// Strictly under the limit, pin to mode output: synchroniser, decision
// edge and output register take the margin out of the whole figure
`define PMC_RES_MARGIN_CYC  4
`define PMC_SLEEP_RES_CYC   ((`PMC_SLEEP_RES_NS * `PMC_CLK_MHZ) / 1000 - `PMC_RES_MARGIN_CYC)
`define PMC_HIB_RES_CYC     ((`PMC_HIB_RES_NS * `PMC_CLK_MHZ) / 1000 - `PMC_RES_MARGIN_CYC)
`define PMC_BUZZ_CYC        1000

`endif

// *** src/pmc_top.v ***
// Global power mode controller with APB registers and glitch-free clock gates
// How it works
// - Four modes: active, alternate, sleep, hibernate.
// - Active template gates each subsystem clock.
// - Alternate mode uses its own template.
// - Sleep disables all but timers and RTC.
// - Sleep runs low-speed clocks, buzzes regulators.
// - Self-disabled CPU returns on next wakeup.
// - Wakeup forces active mode, CPU enabled.
// - Mode after reset is active.
// - Sleep resume shorter than 15 us.
// - Hibernate stops clocks; only pin wakeup.
// - Hibernate holds outputs and pin interrupts.
// - Hibernate resume shorter than 100 us.
// - Configurable wakeups always restore active; in hibernate only the pin interrupt source wakes.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.vh"

module pmc_top #(
  parameter integer N_SUBSYS    = 8,
  parameter integer SLEEP_RES   = `PMC_SLEEP_RES_CYC,
  parameter integer HIB_RES     = `PMC_HIB_RES_CYC,
  parameter integer BUZZ_PERIOD = `PMC_BUZZ_CYC
) (
  input  wire                     I_REF_CLK,
  input  wire                     I_RESET_N,
  input  wire                     I_PSEL,
  input  wire                     I_PENABLE,
  input  wire                     I_PWRITE,
  input  wire [11:0]              I_PADDR,
  input  wire [31:0]              I_PWDATA,
  output wire                     O_PREADY,
  output reg  [31:0]              O_PRDATA,
  output reg                      O_PSLVERR,
  input  wire [`PMC_WAKE_W-1:0]   I_WAKE_SRC,
  output reg  [N_SUBSYS-1:0]      O_SUBSYS_EN,
  output wire [N_SUBSYS-1:0]      O_SUBSYS_CLK,
  output reg  [`PMC_MODE_W-1:0]   O_MODE,
  output reg                      O_LS_OSC_EN,
  output reg                      O_TIMER_KEEP,
  output reg                      O_MAIN_REG_EN,
  output reg                      O_REG_BUZZ,
  output reg                      O_IO_HOLD
);

  localparam [4:0] ST_ACT = 5'h01;
  localparam [4:0] ST_ALT = 5'h02;
  localparam [4:0] ST_SLP = 5'h04;
  localparam [4:0] ST_HIB = 5'h08;
  localparam [4:0] ST_RES = 5'h10;

  reg  [4:0]              state_q;
  reg  [4:0]              state_d;
  reg  [N_SUBSYS-1:0]     act_tmpl_q;
  reg  [N_SUBSYS-1:0]     alt_tmpl_q;
  reg  [`PMC_WAKE_W-1:0]  wake_en_q;
  reg  [`PMC_WAKE_W-1:0]  cause_q;
  reg                     refused_q;
  reg  [13:0]             res_cnt_q;
  reg  [13:0]             res_cnt_d;
  reg  [13:0]             buzz_cnt_q;
  reg  [`PMC_WAKE_W-1:0]  wk_meta_q;
  reg  [`PMC_WAKE_W-1:0]  wk_sync_q;
  reg  [`PMC_WAKE_W-1:0]  wk_prev_q;
  reg  [N_SUBSYS-1:0]     gate_en_q;
  wire                    wr_acc;
  wire                    setup;
  wire [`PMC_MODE_W-1:0]  req_mode;
  wire                    mode_wr;
  wire                    req_ok;
  wire [`PMC_WAKE_W-1:0]  wk_rise;
  wire [`PMC_WAKE_W-1:0]  wk_lvl;
  wire                    wake_act;
  wire                    wake_lp;

  // Decodes a byte address to a mapped register
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a == `PMC_MODE_CTRL_OFS) || (a == `PMC_ACT_TMPL_OFS) ||
                 (a == `PMC_ALT_TMPL_OFS) || (a == `PMC_WAKE_EN_OFS) ||
                 (a == `PMC_STATUS_OFS);
    end
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign O_PREADY = 1'b1;
  assign setup    = I_PSEL & ~I_PENABLE;
  assign wr_acc   = I_PSEL & I_PENABLE & I_PWRITE & addr_hit(I_PADDR);
  assign mode_wr  = wr_acc && (I_PADDR == `PMC_MODE_CTRL_OFS);
  assign req_mode = I_PWDATA[`PMC_MODE_W-1:0];

  assign req_ok = (state_q == ST_ACT) ||
                  ((state_q == ST_ALT) && (req_mode != `PMC_MODE_HIB));

  // Pins and sources are asynchronous to this clock
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wk_meta_q <= {`PMC_WAKE_W{1'b0}};
      wk_sync_q <= {`PMC_WAKE_W{1'b0}};
      wk_prev_q <= {`PMC_WAKE_W{1'b0}};
    end else begin
      wk_meta_q <= I_WAKE_SRC;
      wk_sync_q <= wk_meta_q;
      wk_prev_q <= wk_sync_q;
    end
  end

  assign wk_rise  = wk_sync_q & ~wk_prev_q & wake_en_q;
  assign wk_lvl   = wk_sync_q & wake_en_q;
  assign wake_act = |wk_rise;
  // in hibernate only the pin interrupt unit is heard
  assign wake_lp  = (state_q == ST_HIB) ? wk_lvl[`PMC_WK_PIN_INT] : (|wk_lvl);

  always @* begin
    state_d   = state_q;
    res_cnt_d = res_cnt_q;
    case (state_q)
      ST_ACT, ST_ALT: begin
        if (wake_act) begin
          state_d = ST_ACT;
        end else if (mode_wr && req_ok) begin
          case (req_mode)
            `PMC_MODE_ACTIVE: state_d = ST_ACT;
            `PMC_MODE_ALT:    state_d = ST_ALT;
            `PMC_MODE_SLEEP:  state_d = ST_SLP;
            default:          state_d = ST_HIB;
          endcase
        end
      end
      ST_SLP: begin
        if (wake_lp) begin
          state_d   = ST_RES;
          res_cnt_d = SLEEP_RES[13:0];
        end
      end
      ST_HIB: begin
        if (wake_lp) begin
          state_d   = ST_RES;
          res_cnt_d = HIB_RES[13:0];
        end
      end
      ST_RES: begin
        if (res_cnt_q <= 14'h0001) begin
          state_d   = ST_ACT;
          res_cnt_d = 14'h0000;
        end else begin
          res_cnt_d = res_cnt_q - 14'h0001;
        end
      end
      default: state_d = ST_ACT;
    endcase
  end

  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q   <= ST_ACT;
      res_cnt_q <= 14'h0000;
    end else begin
      state_q   <= state_d;
      res_cnt_q <= res_cnt_d;
    end
  end

  // Registers written by software, plus hardware updates
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      act_tmpl_q <= `PMC_ACT_TMPL_RST;
      alt_tmpl_q <= `PMC_ALT_TMPL_RST;
      wake_en_q  <= `PMC_WAKE_EN_RST;
      refused_q  <= 1'b0;
      cause_q    <= {`PMC_WAKE_W{1'b0}};
    end else begin
      // firmware may change the template at any time
      if (wr_acc && (I_PADDR == `PMC_ACT_TMPL_OFS))
        act_tmpl_q <= I_PWDATA[N_SUBSYS-1:0];
      // wakeup re-enables the CPU, winning over a write
      if ((state_d == ST_ACT) && (wake_act || (state_q == ST_RES)))
        act_tmpl_q[`PMC_CPU_BIT] <= 1'b1;
      if (wr_acc && (I_PADDR == `PMC_ALT_TMPL_OFS))
        alt_tmpl_q <= I_PWDATA[N_SUBSYS-1:0];
      if (wr_acc && (I_PADDR == `PMC_WAKE_EN_OFS))
        wake_en_q <= I_PWDATA[`PMC_WAKE_W-1:0];
      // refused request is recorded, not acted on
      if (mode_wr)
        refused_q <= ~req_ok;
      if (wake_act && (state_q == ST_ACT || state_q == ST_ALT))
        cause_q <= wk_rise;
      else if ((state_q == ST_SLP || state_q == ST_HIB) && wake_lp)
        cause_q <= (state_q == ST_HIB) ? (wk_lvl & 6'h02) : wk_lvl;
    end
  end

  // Read data and error captured in the setup cycle
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRDATA  <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else if (setup) begin
      O_PSLVERR <= ~addr_hit(I_PADDR);
      case (I_PADDR)
        `PMC_MODE_CTRL_OFS: O_PRDATA <= {30'h00000000, O_MODE};
        `PMC_ACT_TMPL_OFS:  O_PRDATA <= {{(32-N_SUBSYS){1'b0}}, act_tmpl_q};
        `PMC_ALT_TMPL_OFS:  O_PRDATA <= {{(32-N_SUBSYS){1'b0}}, alt_tmpl_q};
        `PMC_WAKE_EN_OFS:   O_PRDATA <= {26'h0000000, wake_en_q};
        `PMC_STATUS_OFS:    O_PRDATA <= {18'h00000, cause_q, 4'h0, refused_q,
                                         (state_q == ST_RES), O_MODE};
        default:            O_PRDATA <= 32'h00000000;
      endcase
    end
  end

  // Buzz divider runs only in sleep
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      buzz_cnt_q <= 14'h0000;
      O_REG_BUZZ <= 1'b0;
    end else if (state_q == ST_SLP) begin
      O_REG_BUZZ <= (buzz_cnt_q == BUZZ_PERIOD[13:0] - 14'h0001);
      if (buzz_cnt_q == BUZZ_PERIOD[13:0] - 14'h0001)
        buzz_cnt_q <= 14'h0000;
      else
        buzz_cnt_q <= buzz_cnt_q + 14'h0001;
    end else begin
      buzz_cnt_q <= 14'h0000;
      O_REG_BUZZ <= 1'b0;
    end
  end

  // Mode-dependent outputs, registered
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SUBSYS_EN   <= {N_SUBSYS{1'b0}};
      O_MODE        <= `PMC_MODE_ACTIVE;
      O_LS_OSC_EN   <= 1'b1;
      O_TIMER_KEEP  <= 1'b1;
      O_MAIN_REG_EN <= 1'b1;
      O_IO_HOLD     <= 1'b0;
    end else begin
      case (state_q)
        ST_ACT: begin
          O_SUBSYS_EN <= act_tmpl_q;
          O_MODE      <= `PMC_MODE_ACTIVE;
        end
        ST_ALT: begin
          O_SUBSYS_EN <= alt_tmpl_q;
          O_MODE      <= `PMC_MODE_ALT;
        end
        ST_SLP: begin
          O_SUBSYS_EN <= {N_SUBSYS{1'b0}};
          O_MODE      <= `PMC_MODE_SLEEP;
        end
        ST_HIB: begin
          O_SUBSYS_EN <= {N_SUBSYS{1'b0}};
          O_MODE      <= `PMC_MODE_HIB;
        end
        default: begin
          // Regulators settle before anything is clocked again
          O_SUBSYS_EN <= {N_SUBSYS{1'b0}};
          O_MODE      <= O_MODE;
        end
      endcase
      // no clocks at all in hibernate
      O_LS_OSC_EN   <= (state_q != ST_HIB);
      // timers and RTC kept alive in sleep
      O_TIMER_KEEP  <= (state_q != ST_HIB);
      // main regulators off, hibernate regulator only
      O_MAIN_REG_EN <= (state_q != ST_HIB) && (state_q != ST_SLP);
      // hold pin levels and pin interrupt setup
      O_IO_HOLD     <= (state_q == ST_HIB);
    end
  end

  // Enables latched on the falling edge so the AND sees a stable level
  always @(negedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N)
      gate_en_q <= {N_SUBSYS{1'b0}};
    else
      gate_en_q <= O_SUBSYS_EN;
  end

  genvar g;
  generate
    for (g = 0; g < N_SUBSYS; g = g + 1) begin : g_gate
      // enable changes only while clock is low
      assign O_SUBSYS_CLK[g] = I_REF_CLK & gate_en_q[g];
    end
  endgenerate

endmodule // pmc_top
`default_nettype wire
